//--- design/fbc_pkg.sv
package fbc_pkg;
	// =========================================
	// bus widths
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	// =========================================
	// command addresses and bytes
	localparam logic [16:0] UNLOCK1_ADDR = 17'h00555;
	localparam logic [16:0] UNLOCK2_ADDR = 17'h002AA;
	localparam logic [7:0] UNLOCK1_BYTE = 8'hAA;
	localparam logic [7:0] UNLOCK2_BYTE = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_PROG = 8'hA0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_BYP_EXIT = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_BLOCK = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	// identification read offsets, address bits 1:0
	localparam logic [16:0] ID_MAKER = 17'h00000;
	localparam logic [16:0] ID_PART = 17'h00001;
	localparam logic [16:0] ID_PROT = 17'h00002;
	// =========================================
	// timing at 20 MHz
	localparam int CLK_NS = 50;
	localparam int GLITCH_NS = 5;
	localparam int IDLE_NS = 150;
	localparam int SETUP_NS = 50;
	localparam int STROBE_NS = 100;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int IDLE_CYC = (IDLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 4;
	// =========================================
	// job codes
	typedef enum logic [3:0] {
		FBC_JOB_READ = 4'h0,
		FBC_JOB_RESET = 4'h1,
		FBC_JOB_IDENT = 4'h2,
		FBC_JOB_PROG = 4'h3,
		FBC_JOB_BYPASS = 4'h4,
		FBC_JOB_BYP_PROG = 4'h5,
		FBC_JOB_BYP_EXIT = 4'h6,
		FBC_JOB_CHIP_ERASE = 4'h7,
		FBC_JOB_BLOCK_ERASE = 4'h8,
		FBC_JOB_SUSPEND = 4'h9,
		FBC_JOB_RESUME = 4'hA
	} fbc_job_e;
endpackage : fbc_pkg

//--- design/fbc_seq_rom.sv
`timescale 1ns/1ps
module fbc_seq_rom
	import fbc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] job,
	input wire logic [2:0] step,
	input wire logic [16:0] user_addr,
	input wire logic [7:0] user_byte,
	output logic [16:0] wr_addr_q,
	output logic [7:0] wr_byte_q,
	output logic [2:0] len_q
);
	// =========================================
	// registered lookup of each write of a command
	logic [16:0] a;
	logic [7:0] b;
	logic [2:0] n;
	function automatic logic [7:0] unlock_byte(input logic [2:0] s);
		unlock_byte = (s == 3'h0 || s == 3'h3) ? UNLOCK1_BYTE : UNLOCK2_BYTE;
	endfunction : unlock_byte
	function automatic logic [16:0] unlock_addr(input logic [2:0] s);
		unlock_addr = (s == 3'h1 || s == 3'h4) ? UNLOCK2_ADDR : UNLOCK1_ADDR;
	endfunction : unlock_addr
	always_comb begin
		a = unlock_addr(step);
		b = unlock_byte(step);
		n = 3'h1;
		case (job)
			FBC_JOB_RESET: begin
				n = 3'h1;
				a = user_addr;
				b = CMD_RESET;
			end
			FBC_JOB_IDENT, FBC_JOB_BYPASS: begin
				n = 3'h3;
				if (step == 3'h2) begin
					b = (job == FBC_JOB_IDENT) ? CMD_IDENT : CMD_BYPASS;
				end
			end
			FBC_JOB_PROG: begin
				n = 3'h4;
				if (step == 3'h2) begin
					b = CMD_PROG;
				end else if (step == 3'h3) begin
					a = user_addr;
					b = user_byte;
				end
			end
			FBC_JOB_BYP_PROG, FBC_JOB_BYP_EXIT: begin
				n = 3'h2;
				a = user_addr;
				if (step == 3'h0) begin
					b = (job == FBC_JOB_BYP_PROG) ? CMD_PROG : CMD_IDENT;
				end else begin
					b = (job == FBC_JOB_BYP_PROG) ? user_byte : CMD_BYP_EXIT;
				end
			end
			FBC_JOB_CHIP_ERASE, FBC_JOB_BLOCK_ERASE: begin
				n = 3'h6;
				if (step == 3'h2) begin
					b = CMD_ERASE;
				end else if (step == 3'h5) begin
					b = (job == FBC_JOB_CHIP_ERASE) ? CMD_CHIP : CMD_BLOCK;
					a = (job == FBC_JOB_CHIP_ERASE) ? UNLOCK1_ADDR : user_addr;
				end
			end
			FBC_JOB_SUSPEND, FBC_JOB_RESUME: begin
				n = 3'h1;
				a = user_addr;
				b = (job == FBC_JOB_SUSPEND) ? CMD_SUSPEND : CMD_RESUME;
			end
			default: begin
				n = 3'h0;
				a = user_addr;
				b = user_byte;
			end
		endcase
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_addr_q <= 17'h00000;
			wr_byte_q <= 8'h00;
			len_q <= 3'h0;
		end else begin
			wr_addr_q <= a;
			wr_byte_q <= b;
			len_q <= n;
		end
	end
endmodule : fbc_seq_rom

//--- design/fbc_host.sv
`timescale 1ns/1ps
module fbc_host
	import fbc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic [3:0] req_job,
	input wire logic [16:0] req_addr,
	input wire logic [7:0] req_byte,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_byte,
	output logic [16:0] addr_lines,
	output logic [7:0] byte_lines_out,
	output logic byte_lines_oe,
	input wire logic [7:0] byte_lines_in,
	output logic chip_sel_n,
	output logic out_drv_n,
	output logic wr_stb_n
);
	// =========================================
	// state
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LOOK = 5'b00010,
		ST_SETUP = 5'b00100,
		ST_STROBE = 5'b01000,
		ST_HOLD = 5'b10000
	} fbc_state_e;
	typedef struct packed {
		fbc_state_e st;
		logic [3:0] job;
		logic [16:0] uaddr;
		logic [7:0] ubyte;
		logic [2:0] step;
		logic [CNT_W-1:0] cnt;
		logic rd;
		logic ready;
		logic rvalid;
		logic [7:0] rbyte;
		logic [16:0] addr;
		logic [7:0] dout;
		logic oe;
		logic cs_n;
		logic od_n;
		logic we_n;
	} fbc_s;
	fbc_s s_q, s_d;
	logic [7:0] din_m, din_s;
	logic [16:0] rom_addr;
	logic [7:0] rom_byte;
	logic [2:0] rom_len;
	fbc_seq_rom u_rom (
		.clock(clock),
		.rst_n(rst_n),
		.job(s_q.job),
		.step(s_q.step),
		.user_addr(s_q.uaddr),
		.user_byte(s_q.ubyte),
		.wr_addr_q(rom_addr),
		.wr_byte_q(rom_byte),
		.len_q(rom_len)
	);
	// =========================================
	// pin input synchroniser; capture uses the second stage only
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			din_m <= 8'h00;
			din_s <= 8'h00;
		end else begin
			din_m <= byte_lines_in;
			din_s <= din_m;
		end
	end
	// =========================================
	// sequencer
	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				// bus parked in standby between jobs
				s_d.cs_n = 1'b1;
				s_d.od_n = 1'b1;
				s_d.we_n = 1'b1;
				s_d.oe = 1'b0;
				s_d.ready = 1'b1;
				if (req_valid && s_q.ready) begin
					s_d.ready = 1'b0;
					s_d.job = req_job;
					s_d.uaddr = req_addr;
					s_d.ubyte = req_byte;
					s_d.step = 3'h0;
					s_d.rd = (req_job == FBC_JOB_READ);
					s_d.st = ST_LOOK;
				end
			end
			ST_LOOK: begin
				// one cycle for the registered lookup to settle
				s_d.st = ST_SETUP;
				s_d.cnt = CNT_W'(SETUP_CYC);
			end
			ST_SETUP: begin
				s_d.addr = s_q.rd ? s_q.uaddr : rom_addr;
				s_d.dout = rom_byte;
				// host drives data only on writes, device floated by high out drive
				s_d.oe = !s_q.rd;
				s_d.cs_n = 1'b0;
				if (s_q.cnt <= CNT_W'(1)) begin
					s_d.st = ST_STROBE;
					s_d.cnt = CNT_W'(STROBE_CYC);
				end else begin
					s_d.cnt = s_q.cnt - CNT_W'(1);
				end
			end
			ST_STROBE: begin
				// read strobes; output drive high for writes
				s_d.od_n = !s_q.rd;
				// strobe held far longer than any glitch
				s_d.we_n = s_q.rd;
				if (s_q.cnt <= CNT_W'(1)) begin
					s_d.st = ST_HOLD;
					s_d.cnt = CNT_W'(IDLE_CYC);
				end else begin
					s_d.cnt = s_q.cnt - CNT_W'(1);
				end
			end
			ST_HOLD: begin
				// read byte after two sync stages
				// earlier samples of the second stage predate the drive
				if (s_q.rd && s_q.cnt == CNT_W'(IDLE_CYC - 1)) begin
					s_d.rbyte = din_s;
					s_d.rvalid = 1'b1;
				end
				// data still driven at the rising write edge
				s_d.we_n = 1'b1;
				s_d.od_n = 1'b1;
				s_d.cs_n = 1'b1;
				if (s_q.cnt <= CNT_W'(1)) begin
					s_d.oe = 1'b0;
					// every write of the sequence goes out without a break
					if (!s_q.rd && (s_q.step + 3'h1) < rom_len) begin
						s_d.step = s_q.step + 3'h1;
						s_d.st = ST_LOOK;
					end else begin
						s_d.st = ST_IDLE;
						s_d.ready = 1'b1;
					end
				end else begin
					s_d.cnt = s_q.cnt - CNT_W'(1);
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: ST_IDLE, cs_n: 1'b1, od_n: 1'b1, we_n: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end
	assign req_ready = s_q.ready;
	assign rsp_valid = s_q.rvalid;
	assign rsp_byte = s_q.rbyte;
	assign addr_lines = s_q.addr;
	assign byte_lines_out = s_q.dout;
	assign byte_lines_oe = s_q.oe;
	assign chip_sel_n = s_q.cs_n;
	assign out_drv_n = s_q.od_n;
	assign wr_stb_n = s_q.we_n;
	// =========================================
	// checks
	a_wr_od_high: assert property (@(posedge clock) disable iff (!rst_n)
		!wr_stb_n |-> out_drv_n) else $error("output drive low during write");
	a_no_contention: assert property (@(posedge clock) disable iff (!rst_n)
		!out_drv_n |-> !byte_lines_oe) else $error("host drives data during read");
	a_strobe_len: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(wr_stb_n) |-> !wr_stb_n [*2]) else $error("write strobe too short");
	a_cs_with_wr: assert property (@(posedge clock) disable iff (!rst_n)
		!wr_stb_n |-> !chip_sel_n && byte_lines_oe) else $error("write without select");
	a_addr_stable: assert property (@(posedge clock) disable iff (!rst_n)
		!wr_stb_n && !$past(wr_stb_n) |-> $stable(addr_lines)) else $error("address moved");
	a_read_shape: assert property (@(posedge clock) disable iff (!rst_n)
		!out_drv_n |-> !chip_sel_n && wr_stb_n) else $error("bad read strobes");
	a_read_answer: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(out_drv_n) |-> ##3 rsp_valid) else $error("read answer late");
	a_standby_idle: assert property (@(posedge clock) disable iff (!rst_n)
		req_ready |-> chip_sel_n && !byte_lines_oe) else $error("bus not parked");
endmodule : fbc_host

//--- sim/fbc_flash_model.sv
`timescale 1ns/1ps
module fbc_flash_model
	import fbc_pkg::*;
#(
	parameter logic [7:0] MAKER_ID = 8'h5C, // arbitrary value
	parameter logic [7:0] PART_ID = 8'hC3, // arbitrary value
	parameter logic [7:0] STAT_BUSY = 8'h08,
	parameter logic [7:0] STAT_FAIL = 8'h28,
	parameter logic [7:0] PROT = 8'h80,
	parameter int BUSY_NS = 2000
)(
	input wire logic [16:0] addr_lines,
	input wire logic [7:0] bus,
	input wire logic chip_sel_n,
	input wire logic out_drv_n,
	input wire logic wr_stb_n,
	output logic [7:0] dev_byte,
	output int wr_cnt,
	output int fault_cnt,
	output logic [7:0] last_d
);
	// =========================================
	// array and command state
	logic [7:0] mem [0:131071];
	logic [16:0] lat_a;
	logic [7:0] last = 8'h00;
	logic armed = 0, busy = 0, fail = 0, ident = 0, bypass = 0;
	int step = 0;
	realtime t_low;
	initial foreach (mem[i]) mem[i] = 8'hFF;
	always @* begin
		if (!chip_sel_n && !out_drv_n) begin
			dev_byte = busy ? STAT_BUSY : fail ? STAT_FAIL : !ident ? mem[addr_lines] :
				addr_lines[1:0] == 2'h0 ? MAKER_ID : addr_lines[1:0] == 2'h1 ? PART_ID :
				addr_lines[1:0] == 2'h2 ? {7'h00, PROT[addr_lines[16:14]]} : 8'h00;
			last = dev_byte;
		end else begin
			// no pull-up: show the inverse so a stale sample cannot match
			dev_byte = ~last;
		end
	end
	// address at later fall, data at first rise
	always @(chip_sel_n or wr_stb_n) begin
		if (!chip_sel_n && !wr_stb_n) begin
			lat_a = addr_lines;
			t_low = $realtime;
			armed = 1;
		end else if (armed) begin
			armed = 0;
			if ($realtime - t_low >= GLITCH_NS) begin
				wr_cnt++;
				last_d = bus;
				if (!out_drv_n) fault_cnt++;
				cmd(lat_a, bus);
			end
		end
	end
	// program time as a plain delay
	always @(posedge busy) begin
		#(BUSY_NS);
		busy = 0;
	end
	task automatic cmd(input logic [16:0] a, input logic [7:0] d);
		logic at555;
		at555 = a[10:0] == UNLOCK1_ADDR[10:0];
		if (busy) return;
		if (step == 3 || (bypass && step == 1)) begin
			step = 0;
			if (PROT[a[16:14]]) return;
			fail = |(d & ~mem[a]);
			mem[a] = mem[a] & d;
			busy = 1;
		end else if (d == CMD_RESET) begin
			fail = 0;
			ident = 0;
			step = 0;
		end else if (bypass) begin
			if (step == 5 && d == CMD_BYP_EXIT) bypass = 0;
			step = d == CMD_PROG ? 1 : d == CMD_IDENT ? 5 : 0;
		end else if (step == 0 && at555 && d == UNLOCK1_BYTE) begin
			step = 1;
		end else if (step == 1 && a[10:0] == UNLOCK2_ADDR[10:0] && d == UNLOCK2_BYTE) begin
			step = 2;
		end else if (step == 2 && at555 && d != CMD_ERASE) begin
			ident = d == CMD_IDENT;
			bypass = d == CMD_BYPASS;
			step = d == CMD_PROG ? 3 : 0;
		end else begin
			ident = 0;
			step = 0;
		end
	endtask : cmd
endmodule : fbc_flash_model

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench import fbc_pkg::*;;
	localparam logic [7:0] MK = 8'h5C;
	localparam logic [7:0] PT = 8'hC3;
	localparam logic [7:0] SB = 8'h08;
	localparam logic [7:0] SF = 8'h28;
	logic clock = 0, rst_n = 0, req_valid = 0, req_ready, rsp_valid, byte_lines_oe;
	logic chip_sel_n, out_drv_n, wr_stb_n;
	logic [3:0] req_job = 4'h0;
	logic [16:0] req_addr = 17'h00000, addr_lines;
	logic [7:0] req_byte = 8'h00, rsp_byte, byte_lines_out, dev_byte, bus, last_d;
	int wr_cnt, fault_cnt, rsp_cnt = 0, bad_count = 0, samples_checked = 0;
	assign bus = byte_lines_oe ? byte_lines_out : dev_byte;
	fbc_host u_fbc_host(.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_job(req_job),
		.req_addr(req_addr), .req_byte(req_byte), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_byte(rsp_byte), .addr_lines(addr_lines), .byte_lines_out(byte_lines_out),
		.byte_lines_oe(byte_lines_oe), .byte_lines_in(bus), .chip_sel_n(chip_sel_n),
		.out_drv_n(out_drv_n), .wr_stb_n(wr_stb_n));
	fbc_flash_model #(.MAKER_ID(MK), .PART_ID(PT), .STAT_BUSY(SB), .STAT_FAIL(SF))
		u_fbc_flash_model(.addr_lines(addr_lines), .bus(bus), .chip_sel_n(chip_sel_n),
		.out_drv_n(out_drv_n), .wr_stb_n(wr_stb_n), .dev_byte(dev_byte), .wr_cnt(wr_cnt),
		.fault_cnt(fault_cnt), .last_d(last_d));
	initial forever #25 clock = ~clock;
	always @(negedge clock) if (rsp_valid === 1'b1) rsp_cnt++;
	// =========================================
	// shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic job(input logic [3:0] j, input logic [16:0] a, input logic [7:0] b);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		req_valid = 1;
		req_job = j;
		req_addr = a;
		req_byte = b;
		@(negedge clock);
		req_valid = 0;
		n = 0;
		while (req_ready !== 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		if (n == 200) chk(8'h00, 8'h01);
	endtask : job
	task automatic rd(input logic [16:0] a, input logic [7:0] e);
		int c;
		c = rsp_cnt;
		job(FBC_JOB_READ, a, 8'h00);
		chk(8'(rsp_cnt - c), 8'h01);
		chk(rsp_byte, e);
	endtask : rd
	task automatic close_out;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	// =========================================
	// scenarios
	task automatic t_ident;
		rd(17'h00010, 8'hFF);
		job(FBC_JOB_IDENT, 17'h00000, 8'h00);
		rd(ID_MAKER, MK);
		rd(ID_PART, PT);
		rd(ID_PROT, 8'h00);
		rd(17'h1C002, 8'h01);
		job(FBC_JOB_RESET, 17'h00000, 8'h00);
		rd(17'h1C002, 8'hFF);
		$display("ident done");
	endtask : t_ident
	task automatic t_prog;
		job(FBC_JOB_PROG, 17'h00010, 8'h5A);
		job(FBC_JOB_RESET, 17'h00000, 8'h00);
		rd(17'h00010, SB);
		repeat (60) @(negedge clock);
		rd(17'h00010, 8'h5A);
		job(FBC_JOB_PROG, 17'h00010, 8'hFF);
		repeat (60) @(negedge clock);
		rd(17'h00010, SF);
		job(FBC_JOB_RESET, 17'h00000, 8'h00);
		rd(17'h00010, 8'h5A);
		job(FBC_JOB_PROG, 17'h1C010, 8'h00);
		rd(17'h1C010, 8'hFF);
		$display("program done");
	endtask : t_prog
	task automatic t_bypass;
		job(FBC_JOB_BYPASS, 17'h00000, 8'h00);
		rd(17'h00010, 8'h5A);
		job(FBC_JOB_BYP_PROG, 17'h00011, 8'h33);
		repeat (60) @(negedge clock);
		rd(17'h00011, 8'h33);
		job(FBC_JOB_BYP_EXIT, 17'h00000, 8'h00);
		job(FBC_JOB_BYP_PROG, 17'h00012, 8'h44);
		repeat (60) @(negedge clock);
		rd(17'h00012, 8'hFF);
		$display("bypass done");
	endtask : t_bypass
	task automatic t_table;
		logic [7:0] n [10] = '{1, 3, 4, 3, 2, 2, 6, 6, 1, 1};
		logic [7:0] d [10] = '{8'hF0, 8'h90, 8'h7E, 8'h20, 8'h7E, 8'h00, 8'h10, 8'h30, 8'hB0, 8'h30};
		int c;
		for (int j = 0; j < 10; j++) begin
			c = wr_cnt;
			job(4'(j + 1), 17'h0C123, 8'h7E);
			chk(8'(wr_cnt - c), n[j]);
			chk(last_d, d[j]);
		end
		chk(8'(fault_cnt), 8'h00);
		$display("table done");
	endtask : t_table
	initial begin
		repeat (4) @(negedge clock);
		rst_n = 1;
		t_ident();
		t_prog();
		t_bypass();
		t_table();
		close_out();
	end
	// limit well above the fewer than one thousand cycles the tests need
	initial begin
		#(20000 * 50);
		bad_count++;
		close_out();
	end
endmodule : testbench
